// *** rtl/acm_regmap_defs.vh ***
// constants of the accelerometer register map
`ifndef ACM_REGMAP_DEFS_VH
`define ACM_REGMAP_DEFS_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define ACM_ADDR_REVISION_ID   6'h00
`define ACM_ADDR_STATUS        6'h02
`define ACM_ADDR_ACCEL_X_LOW   6'h04
`define ACM_ADDR_ACCEL_X_HIGH  6'h05
`define ACM_ADDR_ACCEL_Y_LOW   6'h06
`define ACM_ADDR_ACCEL_Y_HIGH  6'h07
`define ACM_ADDR_ACCEL_Z_LOW   6'h08
`define ACM_ADDR_ACCEL_Z_HIGH  6'h09
`define ACM_ADDR_FIFO_READ     6'h0F
`define ACM_ADDR_TEMP_LOW      6'h12
`define ACM_ADDR_TEMP_HIGH     6'h13
`define ACM_ADDR_MODE          6'h14
`define ACM_ADDR_FIFO_FILL     6'h15
`define ACM_ADDR_EVENT_FLAGS   6'h16
`define ACM_ADDR_TWI_POINTER   6'h17
`define ACM_ADDR_IND_INDEX     6'h18
`define ACM_ADDR_LOCK_KEY      6'h1E
`define ACM_ADDR_IRQ_PIN_CFG   6'h21
`define ACM_ADDR_IND_DATA      6'h22

// ------------------------------------------------------------------
// unlock key bytes, in order
// ------------------------------------------------------------------
`define ACM_KEY_FIRST          8'h00
`define ACM_KEY_SECOND         8'h50
`define ACM_KEY_THIRD          8'hA0

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define ACM_RST_MODE           8'h00
`define ACM_RST_TWI_POINTER    8'h00
`define ACM_RST_IND_INDEX      8'h00
`define ACM_RST_BYTE           8'h00

// ------------------------------------------------------------------
// mode field positions
// ------------------------------------------------------------------
`define ACM_MODE_BUF_EN        7
`define ACM_MODE_BUF_8BIT      6
`define ACM_MODE_FFD_EN        4
`define ACM_MODE_SEL_HI        1
`define ACM_MODE_SEL_LO        0

// ------------------------------------------------------------------
// interrupt pin configuration field positions
// ------------------------------------------------------------------
`define ACM_IRQ_FULL_EN        7
`define ACM_IRQ_HALF_EN        6
`define ACM_IRQ_MASK_ALL       1
`define ACM_IRQ_ACT_HIGH       0

`endif

// *** rtl/acm_ind_bank.v ***
// indirect control register bank mirrored from the factory store
`timescale 1ns/100ps
`default_nettype none
`include "acm_regmap_defs.vh"

module acm_ind_bank #(
  parameter NUM_REGS = 16,
  parameter IDX_W    = 4
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  srst,
  // factory image
  input  wire [NUM_REGS*8-1:0] factory_image,
  // host side
  input  wire                  wr_en,
  input  wire [7:0]            index,
  input  wire [7:0]            wdata,
  output reg  [7:0]            rdata,
  // working copy
  output wire [NUM_REGS*8-1:0] regs_flat
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  reg  [7:0] mem [0:NUM_REGS-1];
  wire       in_range;

  assign in_range = ({24'h0000_00, index} < NUM_REGS);

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : g_reg
      // reload from the factory image; no path writes the image back
      always @(posedge clk) begin
        if (srst) begin
          mem[g] <= factory_image[g*8 +: 8];
        end else if (wr_en && in_range && (index[IDX_W-1:0] == g)) begin
          mem[g] <= wdata;
        end
      end
      assign regs_flat[g*8 +: 8] = mem[g];
    end
  endgenerate

  // ------------------------------------------------------------------
  // read selection; out of range reads zero
  // ------------------------------------------------------------------
  always @* begin
    if (in_range) begin
      rdata = mem[index[IDX_W-1:0]];
    end else begin
      rdata = `ACM_RST_BYTE;
    end
  end

endmodule // acm_ind_bank

`default_nettype wire

// *** rtl/acm_regmap.v ***
// host-visible register bank of the three-axis accelerometer
`timescale 1ns/100ps
`default_nettype none
`include "acm_regmap_defs.vh"

module acm_regmap #(
  parameter [7:0] REVISION = 8'h5A,  // arbitrary value
  parameter       NUM_IND  = 16,
  parameter       IND_W    = 4
) (
  // clock and reset
  input  wire                 CLK,
  input  wire                 SRST,
  // register access from the serial engines
  input  wire [5:0]           REG_ADDR,
  input  wire                 REG_WR,
  input  wire [7:0]           REG_WDATA,
  input  wire                 REG_RD,
  output reg  [7:0]           REG_RDATA,
  output reg                  REG_RVALID,
  // sensing datapath
  input  wire [7:0]           STATUS_IN,
  input  wire [15:0]          ACCEL_X,
  input  wire [15:0]          ACCEL_Y,
  input  wire [15:0]          ACCEL_Z,
  input  wire [8:0]           TEMP_IN,
  input  wire [7:0]           EVENT_FLAGS_IN,
  // ring buffer
  input  wire [7:0]           FIFO_DATA,
  input  wire [7:0]           FIFO_LEVEL,
  output reg                  FIFO_POP,
  output reg                  EVENT_ACK,
  // factory store image
  input  wire [7:0]           FACTORY_IRQ_CFG,
  input  wire [NUM_IND*8-1:0] FACTORY_IND,
  // configuration to the rest of the device
  output reg  [7:0]           MODE_CFG,
  output reg                  BUF_EN,
  output reg                  BUF_8BIT,
  output reg                  FFD_EN,
  output reg  [1:0]           MODE_SEL,
  output reg  [7:0]           TWI_READ_POINTER,
  output reg                  IRQ_FULL_EN,
  output reg                  IRQ_HALF_EN,
  output reg                  IRQ_MASK_ALL,
  output reg                  IRQ_ACT_HIGH,
  output reg                  UNLOCKED,
  output wire [NUM_IND*8-1:0] IND_REGS
);

  // ------------------------------------------------------------------
  // lock states
  // ------------------------------------------------------------------
  localparam [1:0] LK_IDLE = 2'b00;
  localparam [1:0] LK_KEY1 = 2'b01;
  localparam [1:0] LK_KEY2 = 2'b10;
  localparam [1:0] LK_OPEN = 2'b11;

  // ------------------------------------------------------------------
  // address decode helpers
  // ------------------------------------------------------------------
  // locations that carry a function; every other one is reserved
  function is_mapped;
    input [5:0] a;
    begin
      case (a)
        `ACM_ADDR_REVISION_ID, `ACM_ADDR_STATUS,
        `ACM_ADDR_ACCEL_X_LOW, `ACM_ADDR_ACCEL_X_HIGH,
        `ACM_ADDR_ACCEL_Y_LOW, `ACM_ADDR_ACCEL_Y_HIGH,
        `ACM_ADDR_ACCEL_Z_LOW, `ACM_ADDR_ACCEL_Z_HIGH,
        `ACM_ADDR_FIFO_READ, `ACM_ADDR_TEMP_LOW, `ACM_ADDR_TEMP_HIGH,
        `ACM_ADDR_MODE, `ACM_ADDR_FIFO_FILL, `ACM_ADDR_EVENT_FLAGS,
        `ACM_ADDR_TWI_POINTER, `ACM_ADDR_IND_INDEX, `ACM_ADDR_LOCK_KEY,
        `ACM_ADDR_IRQ_PIN_CFG, `ACM_ADDR_IND_DATA:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  // the index/data pair sits behind the lock
  function is_locked_reg;
    input [5:0] a;
    begin
      is_locked_reg = (a == `ACM_ADDR_IND_INDEX) ||
                      (a == `ACM_ADDR_IND_DATA);
    end
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  reg  [1:0] lock_state;
  reg  [1:0] next_lock_state;
  reg  [7:0] ind_index;
  reg  [7:0] irq_cfg;
  reg  [7:0] temp_low_hold;
  reg  [7:0] next_rdata;
  wire [7:0] ind_rdata;
  wire       blocked_wr;
  wire       blocked_rd;
  wire       wr_ok;
  wire       rd_ok;
  wire       wr_ind_data;

  // an access is refused while the pair is locked
  assign blocked_wr  = is_locked_reg(REG_ADDR) &&
                       (lock_state != LK_OPEN);
  assign blocked_rd  = blocked_wr;
  assign wr_ok       = REG_WR && is_mapped(REG_ADDR) &&
                       !blocked_wr;
  assign rd_ok       = REG_RD && is_mapped(REG_ADDR) &&
                       !blocked_rd;
  assign wr_ind_data = wr_ok && (REG_ADDR == `ACM_ADDR_IND_DATA);

  // ------------------------------------------------------------------
  // key sequence; any write off the sequence restarts it
  // ------------------------------------------------------------------
  always @* begin
    next_lock_state = lock_state;
    if (REG_WR && (REG_ADDR == `ACM_ADDR_LOCK_KEY)) begin
      case (lock_state)
        LK_IDLE: begin
          next_lock_state = (REG_WDATA == `ACM_KEY_FIRST) ?
                            LK_KEY1 : LK_IDLE;
        end
        LK_KEY1: begin
          if (REG_WDATA == `ACM_KEY_SECOND) begin
            next_lock_state = LK_KEY2;
          end else if (REG_WDATA == `ACM_KEY_FIRST) begin
            next_lock_state = LK_KEY1;
          end else begin
            next_lock_state = LK_IDLE;
          end
        end
        LK_KEY2: begin
          if (REG_WDATA == `ACM_KEY_THIRD) begin
            next_lock_state = LK_OPEN;
          end else if (REG_WDATA == `ACM_KEY_FIRST) begin
            next_lock_state = LK_KEY1;
          end else begin
            next_lock_state = LK_IDLE;
          end
        end
        LK_OPEN: begin
          // a further key write re-engages the lock
          next_lock_state = (REG_WDATA == `ACM_KEY_FIRST) ?
                            LK_KEY1 : LK_IDLE;
        end
        default: begin
          next_lock_state = LK_IDLE;
        end
      endcase
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      lock_state <= LK_IDLE;
      UNLOCKED   <= 1'b0;
    end else begin
      lock_state <= next_lock_state;
      UNLOCKED   <= (next_lock_state == LK_OPEN);
    end
  end

  // ------------------------------------------------------------------
  // read/write configuration registers
  // ------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      MODE_CFG         <= `ACM_RST_MODE;
      TWI_READ_POINTER <= `ACM_RST_TWI_POINTER;
      ind_index        <= `ACM_RST_IND_INDEX;
      irq_cfg          <= FACTORY_IRQ_CFG;
    end else if (wr_ok) begin
      case (REG_ADDR)
        `ACM_ADDR_MODE:        MODE_CFG         <= REG_WDATA;
        `ACM_ADDR_TWI_POINTER: TWI_READ_POINTER <= REG_WDATA;
        `ACM_ADDR_IND_INDEX:   ind_index        <= REG_WDATA;
        // only the working copy changes, never the factory store
        `ACM_ADDR_IRQ_PIN_CFG: irq_cfg          <= REG_WDATA;
        // read-only and unlisted locations ignore the write
        default:               irq_cfg          <= irq_cfg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // decoded configuration outputs
  // ------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      BUF_EN       <= 1'b0;
      BUF_8BIT     <= 1'b0;
      FFD_EN       <= 1'b0;
      MODE_SEL     <= 2'b00;
      IRQ_FULL_EN  <= 1'b0;
      IRQ_HALF_EN  <= 1'b0;
      IRQ_MASK_ALL <= 1'b0;
      IRQ_ACT_HIGH <= 1'b0;
    end else begin
      BUF_EN       <= MODE_CFG[`ACM_MODE_BUF_EN];
      BUF_8BIT     <= MODE_CFG[`ACM_MODE_BUF_8BIT];
      FFD_EN       <= MODE_CFG[`ACM_MODE_FFD_EN];
      MODE_SEL     <= MODE_CFG[`ACM_MODE_SEL_HI:`ACM_MODE_SEL_LO];
      IRQ_FULL_EN  <= irq_cfg[`ACM_IRQ_FULL_EN];
      IRQ_HALF_EN  <= irq_cfg[`ACM_IRQ_HALF_EN];
      IRQ_MASK_ALL <= irq_cfg[`ACM_IRQ_MASK_ALL];
      IRQ_ACT_HIGH <= irq_cfg[`ACM_IRQ_ACT_HIGH];
    end
  end

  // ------------------------------------------------------------------
  // indirect control registers
  // ------------------------------------------------------------------
  acm_ind_bank #(
    .NUM_REGS (NUM_IND),
    .IDX_W    (IND_W)
  ) u_ind_bank (
    .clk           (CLK),
    .srst          (SRST),
    .factory_image (FACTORY_IND),
    .wr_en         (wr_ind_data),
    .index         (ind_index),
    .wdata         (REG_WDATA),
    .rdata         (ind_rdata),
    .regs_flat     (IND_REGS)
  );

  // ------------------------------------------------------------------
  // access-time snapshots
  // ------------------------------------------------------------------
  // high byte read captures the low byte so the pair is coherent
  // the fill count is taken into the read answer only at its own access
  always @(posedge CLK) begin
    if (SRST) begin
      temp_low_hold <= `ACM_RST_BYTE;
    end else begin
      if (rd_ok && (REG_ADDR == `ACM_ADDR_TEMP_HIGH)) begin
        temp_low_hold <= {TEMP_IN[2:0], 5'b00000};
      end
    end
  end

  // ------------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------------
  always @* begin
    next_rdata = `ACM_RST_BYTE;
    if (rd_ok) begin
      case (REG_ADDR)
        `ACM_ADDR_REVISION_ID:  next_rdata = REVISION;
        `ACM_ADDR_STATUS:       next_rdata = STATUS_IN;
        `ACM_ADDR_ACCEL_X_LOW:  next_rdata = ACCEL_X[7:0];
        `ACM_ADDR_ACCEL_X_HIGH: next_rdata = ACCEL_X[15:8];
        `ACM_ADDR_ACCEL_Y_LOW:  next_rdata = ACCEL_Y[7:0];
        `ACM_ADDR_ACCEL_Y_HIGH: next_rdata = ACCEL_Y[15:8];
        `ACM_ADDR_ACCEL_Z_LOW:  next_rdata = ACCEL_Z[7:0];
        `ACM_ADDR_ACCEL_Z_HIGH: next_rdata = ACCEL_Z[15:8];
        `ACM_ADDR_FIFO_READ:    next_rdata = FIFO_DATA;
        `ACM_ADDR_TEMP_LOW:     next_rdata = temp_low_hold;
        `ACM_ADDR_TEMP_HIGH:    next_rdata = {2'b00, TEMP_IN[8:3]};
        `ACM_ADDR_MODE:         next_rdata = MODE_CFG;
        `ACM_ADDR_FIFO_FILL:    next_rdata = FIFO_LEVEL;
        `ACM_ADDR_EVENT_FLAGS:  next_rdata = EVENT_FLAGS_IN;
        `ACM_ADDR_TWI_POINTER:  next_rdata = TWI_READ_POINTER;
        `ACM_ADDR_IND_INDEX:    next_rdata = ind_index;
        `ACM_ADDR_LOCK_KEY:
          next_rdata = {7'b0000000, (lock_state == LK_OPEN)};
        `ACM_ADDR_IRQ_PIN_CFG:  next_rdata = irq_cfg;
        `ACM_ADDR_IND_DATA:     next_rdata = ind_rdata;
        default:                next_rdata = `ACM_RST_BYTE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read answer and side effects
  // ------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA  <= `ACM_RST_BYTE;
      REG_RVALID <= 1'b0;
      FIFO_POP   <= 1'b0;
      EVENT_ACK  <= 1'b0;
    end else begin
      REG_RDATA  <= next_rdata;
      // blocked and reserved reads still answer, with zero
      REG_RVALID <= REG_RD;
      FIFO_POP   <= rd_ok && (REG_ADDR == `ACM_ADDR_FIFO_READ);
      EVENT_ACK  <= rd_ok && (REG_ADDR == `ACM_ADDR_EVENT_FLAGS);
    end
  end

endmodule // acm_regmap

`default_nettype wire

// *** verification/acm_regmap_properties.sv ***
// assertions on the ports of the accelerometer register bank
`timescale 1ns/100ps
`default_nettype none
module acm_regmap_properties #(
  parameter [7:0] REVISION = 8'h5A
) (
  // clock and reset
  input wire logic       CLK,
  input wire logic       SRST,
  // register port
  input wire logic [5:0] REG_ADDR,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  // datapath and configuration
  input wire logic [7:0] FIFO_DATA,
  input wire logic [7:0] FIFO_LEVEL,
  input wire logic       FIFO_POP,
  input wire logic       EVENT_ACK,
  input wire logic [7:0] EVENT_FLAGS_IN,
  input wire logic [7:0] MODE_CFG,
  input wire logic       BUF_EN,
  input wire logic [1:0] MODE_SEL,
  input wire logic [7:0] TWI_READ_POINTER,
  input wire logic       UNLOCKED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [2:0] mode_bits;
  assign mode_bits = {MODE_CFG[7], MODE_CFG[1:0]};
  function automatic logic hole(input logic [5:0] a);
    hole = a == 6'h01 || a == 6'h03 || (a >= 6'h0A && a <= 6'h0E) ||
      a == 6'h10 || a == 6'h11 || (a >= 6'h19 && a <= 6'h1D) ||
      a == 6'h1F || a == 6'h20 || a >= 6'h23;
  endfunction
  property p_hole;
    REG_RD && hole(REG_ADDR) |=> REG_RVALID && REG_RDATA == 8'h00;
  endproperty
  a_hole: assert property (p_hole)
    else $error("reserved read not zero");
  property p_rev;
    REG_RD && REG_ADDR == 6'h00 |=> REG_RDATA == REVISION;
  endproperty
  a_rev: assert property (p_rev)
    else $error("revision read wrong");
  property p_locked;
    REG_RD && !UNLOCKED && (REG_ADDR == 6'h18 || REG_ADDR == 6'h22)
      |=> REG_RVALID && REG_RDATA == 8'h00;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked register readable");
  property p_pop;
    REG_RD && REG_ADDR == 6'h0F |=> FIFO_POP && REG_RDATA == $past(FIFO_DATA);
  endproperty
  a_pop: assert property (p_pop)
    else $error("buffer read not served");
  property p_level;
    REG_RD && REG_ADDR == 6'h15 |=> REG_RDATA == $past(FIFO_LEVEL);
  endproperty
  a_level: assert property (p_level)
    else $error("fill count wrong");
  property p_flags;
    REG_RD && REG_ADDR == 6'h16
      |=> EVENT_ACK && REG_RDATA == $past(EVENT_FLAGS_IN);
  endproperty
  a_flags: assert property (p_flags)
    else $error("event flags read wrong");
  property p_mode;
    REG_WR && REG_ADDR == 6'h14 |=> MODE_CFG == $past(REG_WDATA)
      ##1 {BUF_EN, MODE_SEL} == $past(mode_bits);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode write not applied");
  property p_twi;
    REG_WR && REG_ADDR == 6'h17 |=> TWI_READ_POINTER == $past(REG_WDATA);
  endproperty
  a_twi: assert property (p_twi)
    else $error("read pointer write lost");
  property p_unlock;
    $rose(UNLOCKED) |-> $past(REG_WR) && $past(REG_ADDR) == 6'h1E &&
      $past(REG_WDATA) == 8'hA0;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("lock released without final key");
  c_unlock: cover property ($rose(UNLOCKED));
  c_pop: cover property (FIFO_POP);
  c_ind: cover property (REG_WR && UNLOCKED && REG_ADDR == 6'h22);
endmodule // acm_regmap_properties

bind acm_regmap acm_regmap_properties #(.REVISION(REVISION)) u_props (
  .CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .FIFO_DATA(FIFO_DATA), .FIFO_LEVEL(FIFO_LEVEL),
  .FIFO_POP(FIFO_POP), .EVENT_ACK(EVENT_ACK),
  .EVENT_FLAGS_IN(EVENT_FLAGS_IN), .MODE_CFG(MODE_CFG), .BUF_EN(BUF_EN),
  .MODE_SEL(MODE_SEL), .TWI_READ_POINTER(TWI_READ_POINTER),
  .UNLOCKED(UNLOCKED));
`default_nettype wire

// *** verification/acm_host_model.sv ***
// host processor model that reaches the register bank
`timescale 1ns/100ps
`default_nettype none
module acm_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output var  logic [5:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // write data is scrambled once released
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // answer is taken in the cycle the valid pulse stands
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask
  task automatic unlock;
    wr(6'h1E, 8'h00);
    wr(6'h1E, 8'h50);
    wr(6'h1E, 8'hA0);
  endtask
endmodule // acm_host_model
`default_nettype wire

// *** verification/test_acm_regmap.sv ***
// self-checking testbench of the accelerometer register bank
`timescale 1ns/100ps
`default_nettype none
module test_acm_regmap;
  localparam [7:0] REV = 8'h5A;
  logic clk = 1'b0, srst = 1'b1;
  logic [5:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, fpop, eack, unlocked;
  logic [7:0] reg_wdata, reg_rdata, mode_cfg, twi, d, hi;
  logic buf_en, buf_8bit, ffd_en, i_full, i_half, i_mask, i_high;
  logic [1:0] mode_sel;
  logic [127:0] find, ind_regs;
  logic [15:0] ax = 16'h1234, ay = 16'h5678, az = 16'h9ABC;
  logic [8:0] temp = 9'h1A5;
  logic [7:0] status = 8'h3C, flags = 8'h41, fdata = 8'h77;
  logic [7:0] flevel = 8'h2A, firq = 8'h81;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  acm_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  acm_regmap #(.REVISION(REV), .NUM_IND(16), .IND_W(4)) uut (
    .CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .STATUS_IN(status), .ACCEL_X(ax),
    .ACCEL_Y(ay), .ACCEL_Z(az), .TEMP_IN(temp), .EVENT_FLAGS_IN(flags),
    .FIFO_DATA(fdata), .FIFO_LEVEL(flevel), .FIFO_POP(fpop),
    .EVENT_ACK(eack), .FACTORY_IRQ_CFG(firq), .FACTORY_IND(find),
    .MODE_CFG(mode_cfg), .BUF_EN(buf_en), .BUF_8BIT(buf_8bit),
    .FFD_EN(ffd_en), .MODE_SEL(mode_sel), .TWI_READ_POINTER(twi),
    .IRQ_FULL_EN(i_full), .IRQ_HALF_EN(i_half), .IRQ_MASK_ALL(i_mask),
    .IRQ_ACT_HIGH(i_high), .UNLOCKED(unlocked), .IND_REGS(ind_regs));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic hole(input logic [5:0] a);
    hole = a == 6'h01 || a == 6'h03 || (a >= 6'h0A && a <= 6'h0E) ||
      a == 6'h10 || a == 6'h11 || (a >= 6'h19 && a <= 6'h1D) ||
      a == 6'h1F || a == 6'h20 || a >= 6'h23;
  endfunction
  function automatic logic [7:0] irq4;
    irq4 = {4'h0, i_full, i_half, i_mask, i_high};
  endfunction
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    host.rd(6'h00, d); chk("revision", REV, d);
    host.rd(6'h21, d); chk("pin_cfg", firq, d);
    chk("irq_outputs", 8'h09, irq4());
    host.rd(6'h1E, d); chk("lock_state", 8'h00, d);
  endtask
  task automatic t_holes_readonly;
    logic [7:0] exp [7] = '{status, ax[7:0], ax[15:8], ay[7:0], ay[15:8],
                            az[7:0], az[15:8]};
    for (int a = 0; a < 64; a++) if (hole(6'(a))) begin
      host.wr(6'(a), 8'hFF);
      host.rd(6'(a), d); chk("hole", 8'h00, d);
    end
    host.wr(6'h00, 8'hFF); host.wr(6'h04, 8'h00); host.wr(6'h15, 8'h00);
    host.rd(6'h00, d); chk("rev_kept", REV, d);
    chk("mode_kept", 8'h00, mode_cfg);
    host.rd(6'h02, d); chk("status", exp[0], d);
    for (int i = 0; i < 6; i++) begin
      host.rd(6'h04 + 6'(i), d); chk("accel", exp[i+1], d);
    end
  endtask
  task automatic t_mode_ptr;
    host.wr(6'h14, 8'hC3); repeat (2) @(negedge clk);
    chk("mode_bits", 8'hC3, {buf_en, buf_8bit, 1'b0, ffd_en, 2'b00,
      mode_sel});
    host.wr(6'h14, 8'h10); repeat (2) @(negedge clk);
    chk("ffd_en", 8'h01, {7'h00, ffd_en});
    host.rd(6'h14, d); chk("mode_rb", 8'h10, d);
    host.wr(6'h17, 8'h3A); host.rd(6'h17, d);
    chk("twi_ptr", 8'h3A, twi); chk("twi_rb", 8'h3A, d);
  endtask
  task automatic t_lock;
    host.wr(6'h18, 8'h03);
    host.rd(6'h18, d); chk("idx_locked", 8'h00, d);
    host.rd(6'h22, d); chk("data_locked", 8'h00, d);
    host.wr(6'h1E, 8'h00); host.wr(6'h1E, 8'h50); host.wr(6'h1E, 8'h55);
    host.wr(6'h1E, 8'hA0);
    chk("bad_key", 8'h00, {7'h00, unlocked});
    host.unlock(); @(negedge clk);
    chk("unlocked", 8'h01, {7'h00, unlocked});
    host.rd(6'h18, d); chk("idx_blocked_wr", 8'h00, d);
    host.rd(6'h22, d); chk("ind0", 8'h10, d);
    host.wr(6'h18, 8'h03); host.wr(6'h22, 8'hC5); @(negedge clk);
    chk("ind_copy", 8'hC5, ind_regs[31:24]);
    host.rd(6'h22, d); chk("ind3", 8'hC5, d);
    host.wr(6'h18, 8'h05);
    host.rd(6'h22, d); chk("ind5", 8'h15, d);
    host.wr(6'h1E, 8'h00);
    host.rd(6'h22, d); chk("relocked", 8'h00, d);
  endtask
  task automatic t_stream;
    host.rd(6'h0F, d); chk("fifo0", 8'h77, d);
    chk("pop", 8'h01, {7'h00, fpop});
    @(posedge clk); fdata <= 8'h78; flevel <= 8'h29;
    host.rd(6'h0F, d); chk("fifo1", 8'h78, d);
    host.rd(6'h15, d); chk("level", 8'h29, d);
    chk("no_pop", 8'h00, {7'h00, fpop});
    host.rd(6'h16, d); chk("flags", flags, d);
    chk("ack", 8'h01, {7'h00, eack});
  endtask
  task automatic t_temp;
    host.rd(6'h13, hi);
    @(posedge clk); temp <= 9'h0FF;
    host.rd(6'h12, d);
    chk("temp_hi", 8'h34, hi); chk("temp_lo", 8'hA0, d);
  endtask
  task automatic t_pin_cfg;
    host.wr(6'h21, 8'h42); repeat (2) @(negedge clk);
    chk("irq_new", 8'h06, irq4());
    host.rd(6'h21, d); chk("pin_rb", 8'h42, d);
    @(posedge clk); srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    host.rd(6'h21, d); chk("factory_kept", firq, d);
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) find[8*i +: 8] = 8'h10 + 8'(i);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_holes_readonly();
    t_mode_ptr();
    t_lock();
    t_stream();
    t_temp();
    t_pin_cfg();
    end_of_test();
  end
endmodule // test_acm_regmap
`default_nettype wire
